// File: hw/irbc_ctrl.sv
// Register slave, bus condition detector and start/stop generator.
//
// Functional notes
// - Top select 0: divide by 28..128.
// - Top select 1: divide by 56..256.
// - SDA fall with SCL high sets busy.
// - SDA rise with SCL high clears busy.
// - Busy flag inert in clocked serial format.
// - Write busy 1, inhibit 0 starts.
// - Repeated start uses the same write.
// - Write busy 0, inhibit 0 stops.
// - Inhibit reads 1, writing 1 blocks.
// - Conditions generated only in master mode.
// - SDA level 0 drives low, 1 releases.
// - SDA level changes only with protect 0.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module irbc_ctrl
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    irbc_pkg::irbc_state_t state_reg;
    irbc_pkg::irbc_state_t state_next;
    logic [3:0]  aw_addr_reg;
    logic        aw_full_reg;
    logic [31:0] w_data_reg;
    logic        w_strb_reg;
    logic        w_full_reg;
    logic [7:0]  ifc1_reg;
    logic        busy_reg;
    logic        sda_lvl_reg;
    logic        sda_prev_reg;
    logic        scl_hold_reg;
    logic        sda_hold_reg;
    logic        scl_s;
    logic        sda_s;
    logic        tick;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        do_write;
    logic        wr_ifc1;
    logic        wr_bcc;
    logic        wr_mapped;
    logic        rd_mapped;
    logic        start_det;
    logic        stop_det;
    logic        i2c_fmt;
    logic        master;
    logic        enable;
    logic        cond_ok;
    logic        req_start;
    logic        req_stop;
    logic        scl_low_w;
    logic        sda_low_w;
    logic        rvalid_next;
    logic [7:0]  bcc_rd;
    logic [31:0] rd_word;

    // ------------------------------------------------------------------
    // Pin synchronisers and rate divider
    // ------------------------------------------------------------------
    irbc_sync u_sync_scl
    (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (scl_i),
        .q     (scl_s)
    );

    irbc_sync u_sync_sda
    (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (sda_i),
        .q     (sda_s)
    );

    irbc_rate_div u_div
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .ce       (ce),
        .run      (state_reg != irbc_pkg::IRBC_IDLE),
        .rate_sel (ifc1_reg[irbc_pkg::IFC_RATE_LSB +: irbc_pkg::RATE_W]),
        .tick     (tick)
    );

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    assign aw_take   = s_axi_awvalid && s_axi_awready;
    assign w_take    = s_axi_wvalid && s_axi_wready;
    assign ar_take   = s_axi_arvalid && s_axi_arready;
    assign do_write  = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_mapped = (aw_addr_reg == irbc_pkg::ADDR_IFC1)
                    || (aw_addr_reg == irbc_pkg::ADDR_BCC);
    assign rd_mapped = (s_axi_araddr == irbc_pkg::ADDR_IFC1)
                    || (s_axi_araddr == irbc_pkg::ADDR_BCC);
    assign wr_ifc1   = do_write && w_strb_reg
                    && (aw_addr_reg == irbc_pkg::ADDR_IFC1);
    assign wr_bcc    = do_write && w_strb_reg
                    && (aw_addr_reg == irbc_pkg::ADDR_BCC);
    assign rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);

    assign bcc_rd  = {busy_reg, irbc_pkg::READ_ONE, !sda_oe,
                      irbc_pkg::READ_ONE, !scl_oe, irbc_pkg::READ_ONE,
                      irbc_pkg::READ_ZERO, irbc_pkg::READ_ONE};
    assign rd_word = (s_axi_araddr == irbc_pkg::ADDR_BCC)
                   ? {{irbc_pkg::PAD_W{1'b0}}, bcc_rd}
                   : (s_axi_araddr == irbc_pkg::ADDR_IFC1)
                   ? {{irbc_pkg::PAD_W{1'b0}}, ifc1_reg}
                   : {irbc_pkg::DATA_W{1'b0}};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= irbc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            aw_full_reg   <= (aw_full_reg || aw_take) && !do_write;
            w_full_reg    <= (w_full_reg || w_take) && !do_write;
            s_axi_awready <= !((aw_full_reg || aw_take) && !do_write);
            s_axi_wready  <= !((w_full_reg || w_take) && !do_write);
            if (aw_take)
                aw_addr_reg <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? irbc_pkg::RESP_OKAY
                                          : irbc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= irbc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_rvalid  <= rvalid_next;
            s_axi_arready <= !rvalid_next;
            if (ar_take)
            begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_mapped ? irbc_pkg::RESP_OKAY
                                         : irbc_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers and bus condition detection
    // ------------------------------------------------------------------
    assign enable  = ifc1_reg[irbc_pkg::IFC_ENABLE];
    assign master  = ifc1_reg[irbc_pkg::IFC_MASTER];
    assign i2c_fmt = !ifc1_reg[irbc_pkg::IFC_SYNC_FMT];
    assign start_det = scl_s && sda_prev_reg && !sda_s;
    assign stop_det  = scl_s && !sda_prev_reg && sda_s;

    assign cond_ok   = wr_bcc && !w_data_reg[irbc_pkg::BCC_INHIBIT]
                    && master && i2c_fmt && enable
                    && (state_reg == irbc_pkg::IRBC_IDLE);
    assign req_start = cond_ok && w_data_reg[irbc_pkg::BCC_BUSY];
    assign req_stop  = cond_ok && !w_data_reg[irbc_pkg::BCC_BUSY];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ifc1_reg     <= irbc_pkg::IFC1_RESET;
            sda_lvl_reg  <= irbc_pkg::SDA_LVL_RESET;
            busy_reg     <= 1'b0;
            sda_prev_reg <= 1'b1;
        end
        else if (ce)
        begin
            sda_prev_reg <= sda_s;
            if (wr_ifc1)
                ifc1_reg <= w_data_reg[irbc_pkg::REG_W-1:0];
            if (wr_bcc && !w_data_reg[irbc_pkg::BCC_SDA_WP])
                sda_lvl_reg <= w_data_reg[irbc_pkg::BCC_SDA_LVL];
            if (i2c_fmt && start_det)
                busy_reg <= 1'b1;
            else if (i2c_fmt && stop_det)
                busy_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Start and stop sequencer
    // ------------------------------------------------------------------
    // condition waveforms
    always_comb
    begin
        state_next = state_reg;
        scl_low_w  = 1'b0;
        sda_low_w  = 1'b0;
        case (state_reg)
            irbc_pkg::IRBC_IDLE:
            begin
                scl_low_w = scl_hold_reg;
                sda_low_w = sda_hold_reg;
                if (req_start)
                    state_next = irbc_pkg::IRBC_ST_REL_SDA;
                else if (req_stop)
                    state_next = irbc_pkg::IRBC_SP_SDA_LOW;
            end
            irbc_pkg::IRBC_ST_REL_SDA:
            begin
                scl_low_w = scl_hold_reg;
                if (tick)
                    state_next = irbc_pkg::IRBC_ST_REL_SCL;
            end
            irbc_pkg::IRBC_ST_REL_SCL:
            begin
                if (tick)
                    state_next = irbc_pkg::IRBC_ST_SDA_LOW;
            end
            irbc_pkg::IRBC_ST_SDA_LOW:
            begin
                sda_low_w = 1'b1;
                if (tick)
                    state_next = irbc_pkg::IRBC_ST_SCL_LOW;
            end
            irbc_pkg::IRBC_ST_SCL_LOW:
            begin
                scl_low_w = 1'b1;
                sda_low_w = 1'b1;
                if (tick)
                    state_next = irbc_pkg::IRBC_IDLE;
            end
            irbc_pkg::IRBC_SP_SDA_LOW:
            begin
                scl_low_w = 1'b1;
                sda_low_w = 1'b1;
                if (tick)
                    state_next = irbc_pkg::IRBC_SP_REL_SCL;
            end
            irbc_pkg::IRBC_SP_REL_SCL:
            begin
                sda_low_w = 1'b1;
                if (tick)
                    state_next = irbc_pkg::IRBC_SP_REL_SDA;
            end
            irbc_pkg::IRBC_SP_REL_SDA:
            begin
                if (tick)
                    state_next = irbc_pkg::IRBC_IDLE;
            end
            default:
                state_next = irbc_pkg::IRBC_IDLE;
        endcase
    end

    // Both lines stay held low after a start so that the shifter owns them.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg    <= irbc_pkg::IRBC_IDLE;
            scl_hold_reg <= 1'b0;
            sda_hold_reg <= 1'b0;
            scl_oe       <= 1'b0;
            sda_oe       <= 1'b0;
            scl_o        <= irbc_pkg::PIN_LOW;
            sda_o        <= irbc_pkg::PIN_LOW;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            if (state_reg != irbc_pkg::IRBC_IDLE
                && state_next == irbc_pkg::IRBC_IDLE)
            begin
                scl_hold_reg <= scl_low_w;
                sda_hold_reg <= sda_low_w;
            end
            scl_oe <= enable && scl_low_w;
            sda_oe <= enable && (sda_low_w || !sda_lvl_reg);
            scl_o  <= irbc_pkg::PIN_LOW;
            sda_o  <= irbc_pkg::PIN_LOW;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_cond_write;
        ce && do_write && w_strb_reg && aw_addr_reg == irbc_pkg::ADDR_BCC
           && state_reg == irbc_pkg::IRBC_IDLE && enable;
    endsequence

    property p_busy_set;
        ce && i2c_fmt && start_det |=> busy_reg;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("Start edge did not set busy.");

    property p_busy_clr;
        ce && i2c_fmt && stop_det |=> !busy_reg;
    endproperty
    a_busy_clr: assert property (p_busy_clr)
        else $error("Stop edge did not clear busy.");

    property p_sync_inert;
        s_cond_write and (!i2c_fmt) |=> state_reg == irbc_pkg::IRBC_IDLE;
    endproperty
    a_sync_inert: assert property (p_sync_inert)
        else $error("Condition issued in clocked serial format.");

    property p_start_go;
        s_cond_write and (master && i2c_fmt
            && w_data_reg[irbc_pkg::BCC_BUSY]
            && !w_data_reg[irbc_pkg::BCC_INHIBIT])
            |=> state_reg == irbc_pkg::IRBC_ST_REL_SDA;
    endproperty
    a_start_go: assert property (p_start_go)
        else $error("Start write did not launch a start.");

    property p_start_edge;
        ce && enable && state_reg == irbc_pkg::IRBC_ST_REL_SCL && tick
            ##1 ce |=> sda_oe && !scl_oe;
    endproperty
    a_start_edge: assert property (p_start_edge)
        else $error("SDA did not fall with SCL released.");

    property p_stop_go;
        s_cond_write and (master && i2c_fmt
            && !w_data_reg[irbc_pkg::BCC_BUSY]
            && !w_data_reg[irbc_pkg::BCC_INHIBIT])
            |=> state_reg == irbc_pkg::IRBC_SP_SDA_LOW;
    endproperty
    a_stop_go: assert property (p_stop_go)
        else $error("Stop write did not launch a stop.");

    property p_inhibit;
        s_cond_write and w_data_reg[irbc_pkg::BCC_INHIBIT]
            |=> state_reg == irbc_pkg::IRBC_IDLE;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("Inhibited write issued a condition.");

    property p_slave_inert;
        s_cond_write and (!master) |=> state_reg == irbc_pkg::IRBC_IDLE;
    endproperty
    a_slave_inert: assert property (p_slave_inert)
        else $error("Condition issued outside master mode.");

    property p_sda_drive;
        ce && wr_bcc && enable && !w_data_reg[irbc_pkg::BCC_SDA_WP]
            && !w_data_reg[irbc_pkg::BCC_SDA_LVL] ##1 ce |=> sda_oe;
    endproperty
    a_sda_drive: assert property (p_sda_drive)
        else $error("SDA not driven low after level write.");

    property p_sda_protect;
        ce && wr_bcc && w_data_reg[irbc_pkg::BCC_SDA_WP] |=> $stable(sda_lvl_reg);
    endproperty
    a_sda_protect: assert property (p_sda_protect)
        else $error("Protected write changed SDA level.");

    property p_sync_depth;
        ce && $past(ce) && $past(ce, 2) && $past(ce, 3) && start_det
            |-> !$past(sda_i, 2) && $past(sda_i, 3);
    endproperty
    a_sync_depth: assert property (p_sync_depth)
        else $error("Start seen without two-flop delay.");

endmodule

// File: hw/irbc_pkg.sv
// Shared constants, register map and state encoding of the rate and bus block.
package irbc_pkg;

    // ------------------------------------------------------------------
    // Bus widths and register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W    = 4;
    localparam int          DATA_W    = 32;
    localparam int          REG_W     = 8;
    localparam int          PAD_W     = DATA_W - REG_W;
    localparam logic [3:0]  ADDR_IFC1 = 4'h0;
    localparam logic [3:0]  ADDR_BCC  = 4'h4;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          IFC_ENABLE   = 7;
    localparam int          IFC_SYNC_FMT = 6;
    localparam int          IFC_MASTER   = 5;
    localparam int          IFC_RATE_LSB = 0;
    localparam int          RATE_W       = 4;
    localparam int          RATE_TOP     = 3;
    localparam int          BCC_BUSY     = 7;
    localparam int          BCC_INHIBIT  = 6;
    localparam int          BCC_SDA_LVL  = 5;
    localparam int          BCC_SDA_WP   = 4;
    localparam logic [7:0]  IFC1_RESET   = 8'h00;
    localparam logic        SDA_LVL_RESET = 1'b1;
    localparam logic        READ_ONE     = 1'b1;
    localparam logic        READ_ZERO    = 1'b0;
    localparam logic        PIN_LOW      = 1'b0;

    // ------------------------------------------------------------------
    // Transfer clock divisors, index is the 4-bit rate select
    // ------------------------------------------------------------------
    localparam int          DIV_W = 9;
    localparam int          HALF_W = 8;
    localparam logic [15:0][8:0] RATE_DIV = {
        9'h100, 9'h0E0, 9'h0C8, 9'h0A0, 9'h080, 9'h060, 9'h050, 9'h038,
        9'h080, 9'h070, 9'h064, 9'h050, 9'h040, 9'h030, 9'h028, 9'h01C
    };

    // ------------------------------------------------------------------
    // Start and stop sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IRBC_IDLE       = 3'b000,
        IRBC_ST_REL_SDA = 3'b001,
        IRBC_ST_REL_SCL = 3'b010,
        IRBC_ST_SDA_LOW = 3'b011,
        IRBC_ST_SCL_LOW = 3'b100,
        IRBC_SP_SDA_LOW = 3'b101,
        IRBC_SP_REL_SCL = 3'b110,
        IRBC_SP_REL_SDA = 3'b111
    } irbc_state_t;

endpackage

// File: hw/irbc_rate_div.sv
// Half-period tick generator for the master transfer clock.
`timescale 1ns/1ps
module irbc_rate_div
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [3:0] rate_sel,
    output logic            tick
);

    logic [7:0] cnt_reg;
    logic [7:0] gap_reg;
    logic [8:0] div_w;
    logic [7:0] half_w;
    logic       wrap_w;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // divisor lookup
    assign div_w  = irbc_pkg::RATE_DIV[rate_sel];
    assign half_w = div_w[irbc_pkg::DIV_W-1:1];
    assign wrap_w = (cnt_reg == half_w - 8'h01);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 8'h00;
            tick    <= 1'b0;
        end
        else if (ce)
        begin
            cnt_reg <= (!run || wrap_w) ? 8'h00 : cnt_reg + 8'h01;
            tick    <= run && wrap_w;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            gap_reg <= 8'h00;
        else if (ce)
            gap_reg <= !run ? 8'h00 : (tick ? 8'h01 : gap_reg + 8'h01);
    end

    property p_rate_low;
        @(posedge clock) disable iff (!rst_n)
        ce && tick && run && !rate_sel[irbc_pkg::RATE_TOP]
            && $stable(rate_sel) |-> {gap_reg, 1'b0} == div_w;
    endproperty
    a_rate_low: assert property (p_rate_low)
        else $error("Half period wrong for low rate group.");

    property p_rate_high;
        @(posedge clock) disable iff (!rst_n)
        ce && tick && run && rate_sel[irbc_pkg::RATE_TOP]
            && $stable(rate_sel) |-> {gap_reg, 1'b0} == div_w;
    endproperty
    a_rate_high: assert property (p_rate_high)
        else $error("Half period wrong for high rate group.");

endmodule

// File: hw/irbc_sync.sv
// Two-flop synchroniser for one bus pin input.
`timescale 1ns/1ps
module irbc_sync
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);

    logic meta_reg;

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    // pin synchronisation
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end
        else if (ce)
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// File: test/i2c_rate_and_bus_condition_ctrl_test.sv
// Self-checking bench of the rate and bus condition controller.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t %h %h", $time, g, e); end end
module i2c_rate_and_bus_condition_ctrl_test;
    logic        clock = 0, rst_n = 0, ce = 1, pull_sda = 0;
    logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hF;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic        scl_o, scl_oe, sda_o, sda_oe, scl, sda;
    int          fails = 0, num_checks = 0;

    always #12.5 clock = ~clock;

    irbc_ctrl dut_u (.clock(clock), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe));

    irbc_bus_peer peer_u (.scl_oe(scl_oe), .sda_oe(sda_oe),
        .pull_sda(pull_sda), .scl(scl), .sda(sda));

    task automatic stop_test;
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Upper data bits are random; only the low byte is meaningful.
    task automatic wr(input logic [3:0] a, input logic [7:0] b);
        logic        aw;
        logic        w;
        logic [31:0] x;
        x = $urandom;
        aw = 0;
        w = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {x[31:8], b};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge clock);
            if (awready === 1'b1) aw = 1'b1;
            if (wready === 1'b1) w = 1'b1;
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask

    // The upper divisor table is exactly twice the lower one.
    function automatic int exp_half(input logic [3:0] s);
        int lo[8] = '{28, 40, 48, 64, 80, 100, 112, 128};
        return (s[3] ? 2 * lo[s[2:0]] : lo[s[2:0]]) / 2;
    endfunction

    // Time from the start edge on SDA to SCL low is one half period.
    task automatic start_h(input logic [3:0] s);
        int n;
        n = 0;
        wr(irbc_pkg::ADDR_BCC, 8'h90);
        while (sda_oe !== 1'b0) @(posedge clock);
        while (sda_oe !== 1'b1) @(posedge clock);
        do
        begin
            @(posedge clock);
            n++;
        end
        while (scl_oe !== 1'b1);
        `CHK(n, exp_half(s))
        idle(300);
    endtask

    initial
    begin
        idle(60000);
        fails++;
        stop_test;
    end

    initial
    begin
        void'($urandom(40));
        idle(10);
        rst_n <= 1'b1;
        chk_rd(irbc_pkg::ADDR_IFC1, 32'h0, irbc_pkg::RESP_OKAY);
        chk_rd(irbc_pkg::ADDR_BCC, 32'h7D, irbc_pkg::RESP_OKAY);
        chk_rd(4'h8, 32'h0, irbc_pkg::RESP_SLVERR);
        wr(4'h8, 8'hFF);
        `CHK(r, irbc_pkg::RESP_SLVERR)
        wr(irbc_pkg::ADDR_IFC1, 8'hE0);
        `CHK(r, irbc_pkg::RESP_OKAY)
        wr(irbc_pkg::ADDR_BCC, 8'h90);
        pull_sda <= 1'b1;
        idle($urandom_range(20, 60));
        chk_rd(irbc_pkg::ADDR_BCC, 32'h7D, irbc_pkg::RESP_OKAY);
        pull_sda <= 1'b0;
        idle(20);
        wr(irbc_pkg::ADDR_IFC1, 8'h80);
        wr(irbc_pkg::ADDR_BCC, 8'h90);
        idle(300);
        chk_rd(irbc_pkg::ADDR_BCC, 32'h7D, irbc_pkg::RESP_OKAY);
        wr(irbc_pkg::ADDR_BCC, 8'h00);
        idle(20);
        `CHK(sda_oe, 1'b1)
        chk_rd(irbc_pkg::ADDR_BCC, 32'hDD, irbc_pkg::RESP_OKAY);
        wr(irbc_pkg::ADDR_BCC, 8'h30);
        idle(20);
        chk_rd(irbc_pkg::ADDR_BCC, 32'hDD, irbc_pkg::RESP_OKAY);
        wr(irbc_pkg::ADDR_BCC, 8'h20);
        idle(20);
        chk_rd(irbc_pkg::ADDR_BCC, 32'h7D, irbc_pkg::RESP_OKAY);
        wr(irbc_pkg::ADDR_IFC1, 8'hA0);
        wr(irbc_pkg::ADDR_BCC, 8'hD0);
        idle(300);
        chk_rd(irbc_pkg::ADDR_BCC, 32'h7D, irbc_pkg::RESP_OKAY);
        for (int i = 0; i < 16; i++)
        begin
            wr(irbc_pkg::ADDR_IFC1, 8'hA0 | 8'(i));
            start_h(4'(i));
            chk_rd(irbc_pkg::ADDR_BCC, 32'hD5, irbc_pkg::RESP_OKAY);
        end
        wr(irbc_pkg::ADDR_BCC, 8'h10);
        idle(700);
        chk_rd(irbc_pkg::ADDR_BCC, 32'h7D, irbc_pkg::RESP_OKAY);
        `CHK(scl_o | sda_o, 1'b0)
        stop_test;
    end
endmodule

// File: test/irbc_bus_peer.sv
// Bus lines with pull-ups, shared by the device and a second bus master.
`timescale 1ns/1ps
module irbc_bus_peer
(
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic pull_sda,
    output logic      scl,
    output logic      sda
);
    // Wired-AND: a released line floats to its pull-up level.
    assign scl = scl_oe ? 1'b0 : 1'b1;
    assign sda = (sda_oe | pull_sda) ? 1'b0 : 1'b1;
endmodule
